// ### rtl/sphy_regs_consts.vh
`ifndef SPHY_REGS_CONSTS_VH
`define SPHY_REGS_CONSTS_VH

// ----------------------------------------
// byte offsets
// ----------------------------------------
`define SPHY_OFF_ORIENT      8'h60
`define SPHY_OFF_REM_CAP     8'h64
`define SPHY_OFF_LINK_CAP    8'h68
`define SPHY_OFF_LINK_CTL    8'h6c
`define SPHY_OFF_LINK_CAP2   8'h70
`define SPHY_OFF_LINK_CTL2   8'h74
`define SPHY_OFF_LANE_ERR    8'h78
`define SPHY_OFF_LINK_CTL3   8'h7c
`define SPHY_OFF_EQ_SEL      8'h80
`define SPHY_OFF_EQ_WIN      8'h84
`define SPHY_OFF_R16_STATE   8'h88
`define SPHY_OFF_R16_CTL     8'h8c
`define SPHY_OFF_R16_CAP     8'h90
`define SPHY_OFF_R16_DPM     8'h94
`define SPHY_OFF_R16_EQ_SEL  8'h98
`define SPHY_OFF_R16_EQ_WIN  8'h9c
`define SPHY_OFF_MPORT       8'ha0
`define SPHY_OFF_MRG_SEL     8'ha8
`define SPHY_OFF_MRG_WIN     8'hac
`define SPHY_OFF_RT1_DPM     8'hb0
`define SPHY_OFF_RT2_DPM     8'hb4
`define SPHY_OFF_R32_STATE   8'hb8
`define SPHY_OFF_R32_CTL     8'hbc
`define SPHY_OFF_R32_CAP     8'hc0
`define SPHY_OFF_RX_TS1      8'hc8
`define SPHY_OFF_RX_TS2      8'hcc
`define SPHY_OFF_TX_TS1      8'hd0
`define SPHY_OFF_TX_TS2      8'hd4
`define SPHY_OFF_R32_EQ_SEL  8'hd8
`define SPHY_OFF_R32_EQ_WIN  8'hdc
`define SPHY_OFF_ALT_CAP     8'he0
`define SPHY_OFF_ALT_CTL     8'he4
`define SPHY_OFF_ALT_W1      8'he8
`define SPHY_OFF_ALT_W2      8'hec
`define SPHY_OFF_ALT_MASK    8'hf0
`define SPHY_OFF_IRQ_STATE   8'hf8
`define SPHY_OFF_IRQ_MASK    8'hfc

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define SPHY_LANES           32
`define SPHY_ORIENT_UP       2'h0
`define SPHY_ORIENT_DOWN     2'h1
`define SPHY_ORIENT_CROSS    2'h2
`define SPHY_ORIENT_RSVD     2'h3
`define SPHY_REM_CAP_BITS    3
`define SPHY_RST_ZERO        32'h00000000
`define SPHY_IRQ_BITS        3

`endif

// ### rtl/sphy_regs.v
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "sphy_regs_consts.vh"

// Summary of operation
// - lane selector windows 16-bit equalization control
// - separate selector windows 16 GT/s eq control
// - separate selector windows 32 GT/s eq control
// - one margin selector steers control and status
// - orientation status: 0 upstream, 1 downstream
// - orientation control sets training role, 3 reserved
// - 16 GT/s local parity mismatch sticky, write-one-clear
// - retimer parity mismatch registers sticky, write-one-clear
// - margining port views are read-only 16-bit
// - 32 GT/s capability captured at init, read-only
// - link control writable, mirrored views read-only
// - training-set words read-only link mirrors
// - enable mask writable, alternate data read-only
// - crosslink resolution may show in status two
module sphy_regs (
	// clock and reset
	input  wire        clk_in,
	input  wire        nrst_in,
	// register port
	input  wire [7:0]  addr_in,
	input  wire [31:0] wdata_in,
	input  wire        wr_in,
	input  wire        rd_in,
	output reg  [31:0] rdata_out,
	// device state mirrors
	input  wire        port_down_facing_in,
	input  wire [2:0]  local_orient_cap_in,
	input  wire [31:0] link_capability_in,
	input  wire [15:0] link_state_in,
	input  wire [31:0] link_capability_two_in,
	input  wire [15:0] link_state_two_in,
	input  wire [31:0] lane_error_state_in,
	input  wire [31:0] rate16_state_in,
	input  wire [31:0] rate16_capability_in,
	input  wire [31:0] rate32_state_in,
	input  wire [31:0] rate32_capability_in,
	input  wire [15:0] margin_port_capability_in,
	input  wire [15:0] margin_port_state_in,
	input  wire [15:0] margin_lane_state_in,
	input  wire [31:0] rx_training_set_word1_in,
	input  wire [31:0] rx_training_set_word2_in,
	input  wire [31:0] tx_training_set_word1_in,
	input  wire [31:0] tx_training_set_word2_in,
	input  wire [31:0] alt_protocol_capability_in,
	input  wire [31:0] alt_protocol_word1_in,
	input  wire [31:0] alt_protocol_word2_in,
	// parity mismatch events, one bit per lane
	input  wire [31:0] local_mismatch_in,
	input  wire [31:0] retimer1_mismatch_in,
	input  wire [31:0] retimer2_mismatch_in,
	// controls to the link
	output reg  [1:0]  orientation_role_out,
	output reg  [2:0]  remote_orient_cap_out,
	output reg  [15:0] link_control_out,
	output reg  [15:0] link_control_two_out,
	output reg  [31:0] link_control_three_out,
	output reg  [31:0] rate16_control_out,
	output reg  [31:0] rate32_control_out,
	output reg  [31:0] alt_protocol_control_out,
	output reg  [31:0] alt_protocol_enable_mask_out,
	output reg  [4:0]  margin_lane_out,
	output reg  [15:0] margin_lane_control_out,
	// interrupt
	output reg         irq_out
);

	// ----------------------------------------
	// storage
	// ----------------------------------------
	reg [15:0] eq_ctl_ff      [0:`SPHY_LANES-1];
	reg [7:0]  eq16_ctl_ff    [0:`SPHY_LANES-1];
	reg [7:0]  eq32_ctl_ff    [0:`SPHY_LANES-1];
	reg [15:0] mrg_ctl_ff     [0:`SPHY_LANES-1];
	reg [4:0]  eq_sel_ff;
	reg [4:0]  eq16_sel_ff;
	reg [4:0]  eq32_sel_ff;
	reg [31:0] dpm16_ff;
	reg [31:0] dpm_rt1_ff;
	reg [31:0] dpm_rt2_ff;
	reg [31:0] cap32_ff;
	reg        init_done_ff;
	reg [2:0]  irq_mask_ff;
	reg [31:0] nxt_rdata;
	integer    i;

	wire wr_hit_any = wr_in;

	// sticky per-bit update: set wins over clear
	function [31:0] sticky;
		input [31:0] cur;
		input [31:0] ev;
		input        clr;
		input [31:0] data;
		begin
			sticky = (cur & ~({32{clr}} & data)) | ev;
		end
	endfunction

	function is_addr;
		input [7:0] a;
		input [7:0] off;
		begin
			is_addr = (a == off);
		end
	endfunction

	wire [2:0] irq_state = {|dpm_rt2_ff, |dpm_rt1_ff, |dpm16_ff};

	// ----------------------------------------
	// write side
	// ----------------------------------------
	always @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			orientation_role_out         <= `SPHY_ORIENT_UP;
			remote_orient_cap_out        <= 3'h0;
			link_control_out             <= 16'h0000;
			link_control_two_out         <= 16'h0000;
			link_control_three_out       <= `SPHY_RST_ZERO;
			rate16_control_out           <= `SPHY_RST_ZERO;
			rate32_control_out           <= `SPHY_RST_ZERO;
			alt_protocol_control_out     <= `SPHY_RST_ZERO;
			alt_protocol_enable_mask_out <= `SPHY_RST_ZERO;
			margin_lane_out              <= 5'h00;
			eq_sel_ff                    <= 5'h00;
			eq16_sel_ff                  <= 5'h00;
			eq32_sel_ff                  <= 5'h00;
			dpm16_ff                     <= `SPHY_RST_ZERO;
			dpm_rt1_ff                   <= `SPHY_RST_ZERO;
			dpm_rt2_ff                   <= `SPHY_RST_ZERO;
			cap32_ff                     <= `SPHY_RST_ZERO;
			init_done_ff                 <= 1'b0;
			irq_mask_ff                  <= 3'h0;
			for (i = 0; i < `SPHY_LANES; i = i + 1) begin
				eq_ctl_ff[i]   <= 16'h0000;
				eq16_ctl_ff[i] <= 8'h00;
				eq32_ctl_ff[i] <= 8'h00;
				mrg_ctl_ff[i]  <= 16'h0000;
			end
		end else begin
			// capability frozen after first clock past reset
			if (!init_done_ff) begin
				cap32_ff     <= rate32_capability_in;
				init_done_ff <= 1'b1;
			end
			dpm16_ff <= sticky(dpm16_ff, local_mismatch_in,
				wr_hit_any && is_addr(addr_in, `SPHY_OFF_R16_DPM),
				wdata_in);
			dpm_rt1_ff <= sticky(dpm_rt1_ff, retimer1_mismatch_in,
				wr_hit_any && is_addr(addr_in, `SPHY_OFF_RT1_DPM),
				wdata_in);
			dpm_rt2_ff <= sticky(dpm_rt2_ff, retimer2_mismatch_in,
				wr_hit_any && is_addr(addr_in, `SPHY_OFF_RT2_DPM),
				wdata_in);
			if (wr_in) begin
				case (addr_in)
				`SPHY_OFF_ORIENT: begin
					// reserved code ignored, role keeps last value
					if (wdata_in[17:16] != `SPHY_ORIENT_RSVD)
						orientation_role_out <= wdata_in[17:16];
				end
				`SPHY_OFF_REM_CAP: begin
					// remote field lives in the upper half of the word
					remote_orient_cap_out <= wdata_in[18:16];
				end
				`SPHY_OFF_LINK_CTL:
					link_control_out <= wdata_in[15:0];
				`SPHY_OFF_LINK_CTL2:
					link_control_two_out <= wdata_in[15:0];
				`SPHY_OFF_LINK_CTL3:
					link_control_three_out <= wdata_in;
				`SPHY_OFF_EQ_SEL:
					eq_sel_ff <= wdata_in[4:0];
				`SPHY_OFF_EQ_WIN:
					eq_ctl_ff[eq_sel_ff] <= wdata_in[15:0];
				`SPHY_OFF_R16_CTL:
					rate16_control_out <= wdata_in;
				`SPHY_OFF_R16_EQ_SEL:
					eq16_sel_ff <= wdata_in[4:0];
				`SPHY_OFF_R16_EQ_WIN:
					eq16_ctl_ff[eq16_sel_ff] <= wdata_in[7:0];
				`SPHY_OFF_MRG_SEL:
					margin_lane_out <= wdata_in[4:0];
				`SPHY_OFF_MRG_WIN:
					mrg_ctl_ff[margin_lane_out] <= wdata_in[15:0];
				`SPHY_OFF_R32_CTL:
					rate32_control_out <= wdata_in;
				`SPHY_OFF_R32_EQ_SEL:
					eq32_sel_ff <= wdata_in[4:0];
				`SPHY_OFF_R32_EQ_WIN:
					eq32_ctl_ff[eq32_sel_ff] <= wdata_in[7:0];
				`SPHY_OFF_ALT_CTL:
					alt_protocol_control_out <= wdata_in;
				`SPHY_OFF_ALT_MASK:
					alt_protocol_enable_mask_out <= wdata_in;
				`SPHY_OFF_IRQ_MASK:
					irq_mask_ff <= wdata_in[2:0];
				default: ;
				endcase
			end
		end
	end

	// ----------------------------------------
	// window outputs and interrupt
	// ----------------------------------------
	always @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			margin_lane_control_out <= 16'h0000;
			irq_out                 <= 1'b0;
		end else begin
			margin_lane_control_out <= mrg_ctl_ff[margin_lane_out];
			irq_out                 <= |(irq_state & irq_mask_ff);
		end
	end

	// ----------------------------------------
	// read side
	// ----------------------------------------
	always @* begin
		nxt_rdata = `SPHY_RST_ZERO;
		case (addr_in)
		// orientation and capability words
		`SPHY_OFF_ORIENT: begin
			// status low half, control high half
			nxt_rdata = {14'h0000, orientation_role_out,
				14'h0000, 1'b0, port_down_facing_in};
		end
		`SPHY_OFF_REM_CAP: begin
			// local cap low, remote cap high; upper bits zero
			nxt_rdata = {13'h0000, remote_orient_cap_out,
				13'h0000, local_orient_cap_in};
		end

		// link registers: mirrors and controls
		`SPHY_OFF_LINK_CAP: begin
			nxt_rdata = link_capability_in;
		end
		`SPHY_OFF_LINK_CTL: begin
			nxt_rdata = {link_state_in, link_control_out};
		end
		`SPHY_OFF_LINK_CAP2: begin
			nxt_rdata = link_capability_two_in;
		end
		`SPHY_OFF_LINK_CTL2: begin
			// crosslink resolution carried by status two
			nxt_rdata = {link_state_two_in, link_control_two_out};
		end
		`SPHY_OFF_LANE_ERR: begin
			nxt_rdata = lane_error_state_in;
		end
		`SPHY_OFF_LINK_CTL3: begin
			nxt_rdata = link_control_three_out;
		end

		// equalization window
		`SPHY_OFF_EQ_SEL: begin
			nxt_rdata = {27'h0000000, eq_sel_ff};
		end
		`SPHY_OFF_EQ_WIN: begin
			nxt_rdata = {16'h0000, eq_ctl_ff[eq_sel_ff]};
		end

		// 16 GT/s group
		`SPHY_OFF_R16_STATE: begin
			nxt_rdata = rate16_state_in;
		end
		`SPHY_OFF_R16_CTL: begin
			nxt_rdata = rate16_control_out;
		end
		`SPHY_OFF_R16_CAP: begin
			nxt_rdata = rate16_capability_in;
		end
		`SPHY_OFF_R16_DPM: begin
			nxt_rdata = dpm16_ff;
		end
		`SPHY_OFF_R16_EQ_SEL: begin
			nxt_rdata = {27'h0000000, eq16_sel_ff};
		end
		`SPHY_OFF_R16_EQ_WIN: begin
			nxt_rdata = {24'h000000, eq16_ctl_ff[eq16_sel_ff]};
		end

		// margining
		`SPHY_OFF_MPORT: begin
			nxt_rdata = {margin_port_state_in,
				margin_port_capability_in};
		end
		`SPHY_OFF_MRG_SEL: begin
			nxt_rdata = {27'h0000000, margin_lane_out};
		end
		`SPHY_OFF_MRG_WIN: begin
			// status is the live view of the selected lane
			nxt_rdata = {margin_lane_state_in,
				mrg_ctl_ff[margin_lane_out]};
		end

		// retimer parity mismatch
		`SPHY_OFF_RT1_DPM: begin
			nxt_rdata = dpm_rt1_ff;
		end
		`SPHY_OFF_RT2_DPM: begin
			nxt_rdata = dpm_rt2_ff;
		end

		// 32 GT/s group and training sets
		`SPHY_OFF_R32_STATE: begin
			nxt_rdata = rate32_state_in;
		end
		`SPHY_OFF_R32_CTL: begin
			nxt_rdata = rate32_control_out;
		end
		`SPHY_OFF_R32_CAP: begin
			nxt_rdata = cap32_ff;
		end
		`SPHY_OFF_RX_TS1: begin
			nxt_rdata = rx_training_set_word1_in;
		end
		`SPHY_OFF_RX_TS2: begin
			nxt_rdata = rx_training_set_word2_in;
		end
		`SPHY_OFF_TX_TS1: begin
			nxt_rdata = tx_training_set_word1_in;
		end
		`SPHY_OFF_TX_TS2: begin
			nxt_rdata = tx_training_set_word2_in;
		end
		`SPHY_OFF_R32_EQ_SEL: begin
			nxt_rdata = {27'h0000000, eq32_sel_ff};
		end
		`SPHY_OFF_R32_EQ_WIN: begin
			nxt_rdata = {24'h000000, eq32_ctl_ff[eq32_sel_ff]};
		end

		// alternate protocol
		`SPHY_OFF_ALT_CAP: begin
			nxt_rdata = alt_protocol_capability_in;
		end
		`SPHY_OFF_ALT_CTL: begin
			nxt_rdata = alt_protocol_control_out;
		end
		`SPHY_OFF_ALT_W1: begin
			nxt_rdata = alt_protocol_word1_in;
		end
		`SPHY_OFF_ALT_W2: begin
			nxt_rdata = alt_protocol_word2_in;
		end
		`SPHY_OFF_ALT_MASK: begin
			nxt_rdata = alt_protocol_enable_mask_out;
		end

		// interrupt summary and mask
		`SPHY_OFF_IRQ_STATE: begin
			nxt_rdata = {29'h00000000, irq_state};
		end
		`SPHY_OFF_IRQ_MASK: begin
			nxt_rdata = {29'h00000000, irq_mask_ff};
		end

		// unmapped and reserved words read zero
		default: begin
			nxt_rdata = `SPHY_RST_ZERO;
		end
		endcase
	end

	always @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in)
			rdata_out <= `SPHY_RST_ZERO;
		else if (rd_in)
			rdata_out <= nxt_rdata;
		else
			rdata_out <= `SPHY_RST_ZERO;
	end

endmodule

`default_nettype wire

// ### dv/sphy_regs_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "sphy_regs_consts.vh"
module sphy_regs_props (
	// clock and reset
	input wire logic        clk_in,
	input wire logic        nrst_in,
	// register port
	input wire logic [7:0]  addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic        wr_in,
	input wire logic        rd_in,
	input wire logic [31:0] rdata_out,
	input wire logic        port_down_facing_in,
	// controls
	input wire logic [1:0]  orientation_role_out,
	input wire logic [15:0] link_control_out,
	input wire logic [4:0]  margin_lane_out,
	input wire logic [31:0] alt_protocol_enable_mask_out,
	input wire logic        irq_out
);
default clocking cb @(posedge clk_in); endclocking
default disable iff (!nrst_in);
// ----------------------------------------
// sequences
// ----------------------------------------
sequence s_rd_orient;
	rd_in && addr_in == `SPHY_OFF_ORIENT;
endsequence
sequence s_wr_orient;
	wr_in && addr_in == `SPHY_OFF_ORIENT;
endsequence
// irq lags the mask by two edges; no write may reopen it meanwhile
sequence s_mask_off;
	wr_in && addr_in == `SPHY_OFF_IRQ_MASK && wdata_in[2:0] == 3'h0
	##1 (!wr_in)[*3];
endsequence
// ----------------------------------------
// properties
// ----------------------------------------
property p_rd_idle;
	!rd_in |=> rdata_out == 32'h0;
endproperty
property p_orient_rd;
	s_rd_orient |=> rdata_out == {14'h0, $past(orientation_role_out),
		15'h0, $past(port_down_facing_in)};
endproperty
property p_role_wr;
	s_wr_orient ##0 wdata_in[17:16] != 2'h3
	|=> orientation_role_out == $past(wdata_in[17:16]);
endproperty
property p_role_rsvd;
	s_wr_orient ##0 wdata_in[17:16] == 2'h3
	|=> $stable(orientation_role_out);
endproperty
property p_lctl;
	wr_in && addr_in == `SPHY_OFF_LINK_CTL
	|=> link_control_out == $past(wdata_in[15:0]);
endproperty
property p_mask;
	wr_in && addr_in == `SPHY_OFF_ALT_MASK
	|=> alt_protocol_enable_mask_out == $past(wdata_in);
endproperty
property p_msel;
	wr_in && addr_in == `SPHY_OFF_MRG_SEL
	|=> margin_lane_out == $past(wdata_in[4:0]);
endproperty
property p_irq_off;
	s_mask_off |-> !irq_out;
endproperty
a_rd_idle: assert property (p_rd_idle)
	else $error("read data outside read cycle");
a_orient_rd: assert property (p_orient_rd)
	else $error("orientation word read wrong");
a_role_wr: assert property (p_role_wr)
	else $error("orientation control not taken");
a_role_rsvd: assert property (p_role_rsvd)
	else $error("reserved orientation code taken");
a_lctl: assert property (p_lctl)
	else $error("link control not taken");
a_mask: assert property (p_mask)
	else $error("enable mask not taken");
a_msel: assert property (p_msel)
	else $error("margin lane selector not taken");
a_irq_off: assert property (p_irq_off)
	else $error("interrupt while fully masked");
endmodule
bind sphy_regs sphy_regs_props u_props (.clk_in, .nrst_in, .addr_in,
	.wdata_in, .wr_in, .rd_in, .rdata_out, .port_down_facing_in,
	.orientation_role_out, .link_control_out, .margin_lane_out,
	.alt_protocol_enable_mask_out, .irq_out);
`default_nettype wire

// ### dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "sphy_regs_consts.vh"
module testbench;
// ----------------------------------------
// signals and model
// ----------------------------------------
logic             clk_in, nrst_in, wr_in, rd_in, port_down_facing_in;
logic [7:0]       addr_in;
logic [31:0]      wdata_in, c32, v[19], mi[3], st[3], rw[256];
logic [2:0]       local_orient_cap_in;
logic [15:0]      w[4][32];
logic [4:0]       sl[4];
logic [1:0]       role;
wire logic [31:0] rdata_out, alt_protocol_enable_mask_out;
wire logic [15:0] link_control_out, margin_lane_control_out;
wire logic [4:0]  margin_lane_out;
wire logic [1:0]  orientation_role_out;
wire logic        irq_out;
int               bad_count, n_compared, cyc, i, j;
integer           seed = 32'hebc34337;
localparam logic [7:0] SA[4] = '{`SPHY_OFF_EQ_SEL, `SPHY_OFF_R16_EQ_SEL,
	`SPHY_OFF_R32_EQ_SEL, `SPHY_OFF_MRG_SEL};
localparam logic [7:0] WA[4] = '{`SPHY_OFF_EQ_WIN, `SPHY_OFF_R16_EQ_WIN,
	`SPHY_OFF_R32_EQ_WIN, `SPHY_OFF_MRG_WIN};
localparam logic [15:0] WM[4] = '{16'hffff, 16'h00ff, 16'h00ff, 16'hffff};
localparam logic [7:0] DA[3] = '{`SPHY_OFF_R16_DPM, `SPHY_OFF_RT1_DPM,
	`SPHY_OFF_RT2_DPM};
localparam logic [7:0] RA[14] = '{`SPHY_OFF_LINK_CAP, `SPHY_OFF_LINK_CAP2,
	`SPHY_OFF_LANE_ERR, `SPHY_OFF_R16_STATE, `SPHY_OFF_R16_CAP,
	`SPHY_OFF_R32_STATE, `SPHY_OFF_R32_CAP, `SPHY_OFF_RX_TS1,
	`SPHY_OFF_RX_TS2, `SPHY_OFF_TX_TS1, `SPHY_OFF_TX_TS2,
	`SPHY_OFF_ALT_CAP, `SPHY_OFF_ALT_W1, `SPHY_OFF_ALT_W2};
sphy_regs dut_u (
	.clk_in, .nrst_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
	.port_down_facing_in, .local_orient_cap_in,
	.link_capability_in(v[0]), .link_capability_two_in(v[1]),
	.lane_error_state_in(v[2]), .rate16_state_in(v[3]),
	.rate16_capability_in(v[4]), .rate32_state_in(v[5]),
	.rate32_capability_in(v[6]), .rx_training_set_word1_in(v[7]),
	.rx_training_set_word2_in(v[8]), .tx_training_set_word1_in(v[9]),
	.tx_training_set_word2_in(v[10]), .alt_protocol_capability_in(v[11]),
	.alt_protocol_word1_in(v[12]), .alt_protocol_word2_in(v[13]),
	.link_state_in(v[14][15:0]), .link_state_two_in(v[15][15:0]),
	.margin_port_capability_in(v[16][15:0]),
	.margin_port_state_in(v[17][15:0]), .margin_lane_state_in(v[18][15:0]),
	.local_mismatch_in(mi[0]), .retimer1_mismatch_in(mi[1]),
	.retimer2_mismatch_in(mi[2]), .orientation_role_out,
	.remote_orient_cap_out(), .link_control_out, .link_control_two_out(),
	.link_control_three_out(), .rate16_control_out(),
	.rate32_control_out(), .alt_protocol_control_out(),
	.alt_protocol_enable_mask_out, .margin_lane_out,
	.margin_lane_control_out, .irq_out);
initial begin
	clk_in = 1'b0;
	forever #4 clk_in = ~clk_in;
end
// ----------------------------------------
// tasks
// ----------------------------------------
task ck(input string n, input logic [31:0] s, input logic [31:0] x);
	n_compared++;
	if (s !== x) begin
		bad_count++;
		$display("wrong value %s expected %h seen %h", n, x, s);
	end
endtask
function logic [31:0] ex(input logic [7:0] a);
	ex = rw[a];
	for (int k = 0; k < 14; k++)
		if (a == RA[k]) ex = (k == 6) ? c32 : v[k];
	for (int k = 0; k < 4; k++) begin
		if (a == SA[k]) ex = {27'h0, sl[k]};
		if (a == WA[k]) ex = {16'h0, w[k][sl[k]]};
	end
	for (int k = 0; k < 3; k++)
		if (a == DA[k]) ex = st[k];
	case (a)
	`SPHY_OFF_ORIENT: ex = {14'h0, role, 15'h0, port_down_facing_in};
	`SPHY_OFF_REM_CAP: ex = rw[a] | {29'h0, local_orient_cap_in};
	`SPHY_OFF_LINK_CTL: ex = rw[a] | {v[14][15:0], 16'h0};
	`SPHY_OFF_LINK_CTL2: ex = rw[a] | {v[15][15:0], 16'h0};
	`SPHY_OFF_MPORT: ex = {v[17][15:0], v[16][15:0]};
	`SPHY_OFF_MRG_WIN: ex = {v[18][15:0], w[3][sl[3]]};
	`SPHY_OFF_IRQ_STATE: ex = {29'h0, |st[2], |st[1], |st[0]};
	default: ;
	endcase
endfunction
task wr(input logic [7:0] a, input logic [31:0] d);
	@(posedge clk_in);
	addr_in <= a;
	wdata_in <= d;
	wr_in <= 1'b1;
	@(posedge clk_in);
	wr_in <= 1'b0;
	for (int k = 0; k < 4; k++) begin
		if (a == SA[k]) sl[k] = d[4:0];
		if (a == WA[k]) w[k][sl[k]] = d[15:0] & WM[k];
	end
	for (int k = 0; k < 3; k++)
		if (a == DA[k]) st[k] &= ~d;
	if (a == `SPHY_OFF_ORIENT && d[17:16] != 2'h3) role = d[17:16];
	case (a)
	`SPHY_OFF_REM_CAP: rw[a] = d & 32'h00070000;
	`SPHY_OFF_LINK_CTL, `SPHY_OFF_LINK_CTL2: rw[a] = d & 32'h0000ffff;
	`SPHY_OFF_IRQ_MASK: rw[a] = d & 32'h00000007;
	`SPHY_OFF_LINK_CTL3, `SPHY_OFF_R16_CTL, `SPHY_OFF_R32_CTL,
	`SPHY_OFF_ALT_CTL, `SPHY_OFF_ALT_MASK: rw[a] = d;
	default: ;
	endcase
endtask
task rd(input logic [7:0] a);
	@(posedge clk_in);
	addr_in <= a;
	rd_in <= 1'b1;
	@(posedge clk_in);
	rd_in <= 1'b0;
	#1 ck($sformatf("reg %h", a), rdata_out, ex(a));
endtask
// sparse events so that clearing single bits matters
task ev;
	@(posedge clk_in);
	port_down_facing_in <= $random(seed);
	local_orient_cap_in <= $random(seed);
	for (int k = 0; k < 19; k++)
		v[k] <= $random(seed);
	for (int k = 0; k < 3; k++)
		mi[k] <= $random(seed) & $random(seed) & $random(seed);
	@(posedge clk_in);
	for (int k = 0; k < 3; k++) begin
		st[k] |= mi[k];
		mi[k] <= 32'h0;
	end
endtask
task chk;
	repeat (2) @(posedge clk_in);
	#1 ck("role", orientation_role_out, role);
	ck("link ctl", link_control_out, rw[`SPHY_OFF_LINK_CTL]);
	ck("mask", alt_protocol_enable_mask_out, rw[`SPHY_OFF_ALT_MASK]);
	ck("lane", margin_lane_out, sl[3]);
	ck("mctl", margin_lane_control_out, w[3][sl[3]]);
	ck("irq", irq_out, |(ex(`SPHY_OFF_IRQ_STATE) & rw[8'hfc]));
endtask
task summarize;
	$display("compared %0d mismatches %0d", n_compared, bad_count);
	if (bad_count == 0 && n_compared > 0)
		$display("Simulation passed");
	else
		$display("Simulation failed");
	$finish;
endtask
always @(posedge clk_in) begin
	cyc++;
	if (cyc == 10000) begin
		bad_count++;
		summarize();
	end
end
// ----------------------------------------
// sequence
// ----------------------------------------
initial begin
	{nrst_in, wr_in, rd_in, port_down_facing_in} = 4'h0;
	{addr_in, wdata_in, local_orient_cap_in, role} = 45'h0;
	rw = '{default: 32'h0};
	w = '{default: '{default: 16'h0}};
	sl = '{default: 5'h0};
	st = '{default: 32'h0};
	mi = '{default: 32'h0};
	for (i = 0; i < 19; i++)
		v[i] = $random(seed);
	c32 = v[6];
	repeat (5) @(posedge clk_in);
	nrst_in <= 1'b1;
	for (i = 0; i < 40; i++)
		rd(8'h60 + 8'(i * 4));
	for (j = 0; j < 4; j++)
		for (i = 0; i < 32; i++) begin
			wr(SA[j], i);
			wr(WA[j], $random(seed));
		end
	for (j = 0; j < 4; j++)
		for (i = 0; i < 32; i++) begin
			wr(SA[j], i);
			rd(WA[j]);
		end
	for (i = 0; i < 4; i++) begin
		wr(`SPHY_OFF_ORIENT, i << 16);
		rd(`SPHY_OFF_ORIENT);
	end
	repeat (300) begin
		ev();
		j = {$random(seed)} % 40;
		wr(8'h60 + 8'(j * 4), $random(seed));
		rd(8'h60 + 8'(j * 4));
		rd(`SPHY_OFF_IRQ_STATE);
		chk();
	end
	summarize();
end
endmodule
`default_nettype wire
